// file: rtl/sblin_baud_gen.sv
/*
 * Fractional baud generator: sample and bit enables from core_clk_i.
 * Assumes configuration is stable or may change at any time; a change
 * restarts the count.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sblin_defs.svh"

module sblin_baud_gen
   import sblin_pkg::*;
#(
   parameter int CD_W = 16
) (
   input  wire logic            core_clk_i,
   input  wire logic            sys_rst_i,
   input  wire sblin_baud_cfg_t cfg_i,
   output var  logic            sample_tick_o,
   output var  logic            bit_tick_o
);

   generate
      if (CD_W < 1 || CD_W > 16) begin : g_chk
         $error("sblin_baud_gen: CD_W must be 1 to 16");
      end
   endgenerate

   localparam int ACC_W = CD_W + 4;
   localparam logic [ACC_W-1:0] STEP = ACC_W'(`SBLIN_FRAC_STEPS);

   logic [ACC_W-1:0] acc_reg;
   logic [ACC_W-1:0] acc_next;
   logic [4:0]       ovs_reg;
   logic [4:0]       ovs_next;
   logic             sample_next;
   logic             bit_next;
   sblin_baud_cfg_t  cfg_reg;

   // Sample period in eighths of a cycle: 8*CD + FP
   wire logic [ACC_W-1:0] period_w  = {cfg_i.clock_divisor[CD_W-1:0], 3'b000}
                                      + ACC_W'(cfg_i.fraction_part);
   wire logic             run_w     = cfg_i.clock_divisor[CD_W-1:0] != '0;
   wire logic [ACC_W-1:0] acc_add_w = acc_reg + STEP;
   // A new setting restarts the count; a stale phase could give one short sample gap
   wire logic             restart_w = cfg_i != cfg_reg;
   wire logic             wrap_w    = run_w && !restart_w && (acc_add_w >= period_w);
   wire logic [4:0]       ovs_last_w = cfg_i.sampling_ratio_select
                                      ? 5'(`SBLIN_OVS_HALF - 1)
                                      : 5'(`SBLIN_OVS_NORMAL - 1);

   // Zero fraction keeps whole-cycle periods; nonzero spreads eighths over samples
   assign acc_next    = (!run_w || restart_w) ? '0
                        : (wrap_w ? acc_add_w - period_w : acc_add_w);
   assign sample_next = wrap_w;
   // Bit rate = clock / (8*(2-over)*(CD+FP/8)); over=0 with FP=0 gives clock/(16*CD)
   assign bit_next    = wrap_w && (ovs_reg >= ovs_last_w);
   assign ovs_next    = (!run_w || restart_w) ? 5'h00
                        : (bit_next ? 5'h00 : (wrap_w ? ovs_reg + 5'h01 : ovs_reg));

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         acc_reg       <= '0;
         cfg_reg       <= '0;
         ovs_reg       <= 5'h00;
         sample_tick_o <= 1'b0;
         bit_tick_o    <= 1'b0;
      end else begin
         acc_reg       <= acc_next;
         cfg_reg       <= cfg_i;
         ovs_reg       <= ovs_next;
         sample_tick_o <= sample_next;
         bit_tick_o    <= bit_next;
      end
   end

endmodule

`default_nettype wire

// file: rtl/sblin_defs.svh
/*
 * Offsets, field positions, reset values and counts of the serial baud and
 * LIN status block. Assumes a byte address of eight bits on the register port.
 */
`ifndef SBLIN_DEFS_SVH
`define SBLIN_DEFS_SVH

`define SBLIN_ADDR_W          8
`define SBLIN_OFF_CTRL        8'h00
`define SBLIN_OFF_MODE        8'h04
`define SBLIN_OFF_STAT        8'h14
`define SBLIN_OFF_BAUD        8'h20
`define SBLIN_OFF_ISTAT       8'h28
`define SBLIN_OFF_IMASK       8'h2c

`define SBLIN_CTRL_CLR_BIT    8
`define SBLIN_MODE_LSB        0
`define SBLIN_MODE_MSB        3
`define SBLIN_OVER_BIT        19
`define SBLIN_LIN_MODE_A      4'ha
`define SBLIN_LIN_MODE_B      4'hb

`define SBLIN_CD_LSB          0
`define SBLIN_CD_MSB          15
`define SBLIN_FP_LSB          16
`define SBLIN_FP_MSB          18

`define SBLIN_BIT_HTE         31
`define SBLIN_BIT_STE         30
`define SBLIN_BIT_SNRE        29
`define SBLIN_BIT_CE          28
`define SBLIN_BIT_IPE         27
`define SBLIN_BIT_ISFE        26
`define SBLIN_BIT_BE          25
`define SBLIN_BIT_BLS         23
`define SBLIN_BIT_TC          15
`define SBLIN_BIT_ID          14
`define SBLIN_BIT_BK          13
`define SBLIN_BIT_TX_DRAINED_FLAG     9
`define SBLIN_BIT_TIMEOUT     8
`define SBLIN_BIT_PARITY_ERR_FLAG        7
`define SBLIN_BIT_FRAME       6
`define SBLIN_BIT_OVERRUN_FLAG        5
`define SBLIN_BIT_TXROOM      1
`define SBLIN_BIT_RXAVAIL     0

`define SBLIN_LIN_ONLY_MASK   32'hff80e000
`define SBLIN_STICKY_MASK     32'hfe0001e0
`define SBLIN_RST_WORD        32'h00000000
`define SBLIN_RST_BAUD        32'h00000000
`define SBLIN_RST_MODE        4'h0

`define SBLIN_FRAC_STEPS      8
`define SBLIN_OVS_NORMAL      16
`define SBLIN_OVS_HALF        8

`endif

// file: rtl/sblin_pin_sync.sv
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes inputs are asynchronous to core_clk_i.
 */
`timescale 1ns/10ps
`default_nettype none

module sblin_pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic [WIDTH-1:0] pin_i,
   output var  logic [WIDTH-1:0] level_o
);

   generate
      if (WIDTH < 1) begin : g_chk
         $error("sblin_pin_sync: WIDTH must be at least 1");
      end
   endgenerate

   logic [WIDTH-1:0] ff1_reg;
   logic [WIDTH-1:0] ff2_reg;
   logic [WIDTH-1:0] ff3_reg;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         // Second and third stages must agree, so one metastable sample is not a change
         always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               ff1_reg[i] <= 1'b0;
               ff2_reg[i] <= 1'b0;
               ff3_reg[i] <= 1'b0;
               level_o[i] <= 1'b0;
            end else begin
               ff1_reg[i] <= pin_i[i];
               ff2_reg[i] <= ff1_reg[i];
               ff3_reg[i] <= ff2_reg[i];
               if (ff2_reg[i] == ff3_reg[i]) begin
                  level_o[i] <= ff3_reg[i];
               end
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// file: rtl/sblin_pkg.sv
/*
 * Types shared by the serial baud and LIN status block.
 * Assumes the constants header is compiled alongside.
 */
package sblin_pkg;

   // One-cycle event pulses from the serial engine on core_clk_i
   typedef struct packed {
      logic hdr_timeout;
      logic sync_tol;
      logic resp_silent;
      logic checksum;
      logic id_parity;
      logic incons_sync;
      logic bit_err;
      logic rx_timeout;
      logic parity;
      logic framing;
      logic overrun;
   } sblin_evt_t;

   // Levels from the serial engine on core_clk_i
   typedef struct packed {
      logic xfer_done;
      logic ident;
      logic brk;
      logic tx_drained;
      logic tx_room;
      logic rx_avail;
   } sblin_lvl_t;

   typedef struct packed {
      logic [2:0]  fraction_part;
      logic [15:0] clock_divisor;
      logic        sampling_ratio_select;
   } sblin_baud_cfg_t;

endpackage

// file: rtl/sblin_top.sv
/*
 * Serial baud generation and LIN channel status with register port and
 * interrupt. Assumes event pulses and levels from the serial engine are on
 * core_clk_i; the receive line pin is asynchronous.
 */
// Notes on behaviour
// - Without fraction and with ratio select 0, bit rate is clock over sixteen times divisor.
// - Zero fraction: rate steps only in whole-cycle divisions.
// - Nonzero fraction_part enables fractional division in eighth steps.
// - Rate equals clock over 8*(2-ratio select)*(divisor+fraction/8).
// - LIN status fields only show when mode is 0xA or 0xB.
// - Header timeout error at bit 31, sticky until status clear.
// - Sync tolerance error at bit 30, sticky until status clear.
// - Responder silent error at bit 29, sticky until status clear.
// - Checksum error at bit 28, cleared by clear_status_cmd.
// - clear_status_cmd clears sticky errors; flags show errors since last clear.
// - Bits 27, 26, 25 parity, sync, bit errors; 23 line state; reset zero.
`timescale 1ns/10ps
`default_nettype none
`include "sblin_defs.svh"

module sblin_top
   import sblin_pkg::*;
#(
   parameter int CD_W = 16
) (
   input  wire logic                     core_clk_i,
   input  wire logic                     sys_rst_i,
   input  wire logic [`SBLIN_ADDR_W-1:0] addr_i,
   input  wire logic [31:0]              wr_data_i,
   input  wire logic                     wr_stb_i,
   input  wire logic                     rd_stb_i,
   output var  logic [31:0]              rd_data_o,
   input  wire sblin_evt_t               evt_i,
   input  wire sblin_lvl_t               lvl_i,
   input  wire logic                     line_rx_i,
   output var  logic                     sample_tick_o,
   output var  logic                     bit_tick_o,
   output var  logic                     lin_mode_o,
   output var  logic                     irq_o
);

   generate
      if (CD_W < 1 || CD_W > 16) begin : g_chk
         $error("sblin_top: CD_W must be 1 to 16");
      end
   endgenerate

   // Places one event pulse per bit at its status word position
   function automatic logic [31:0] evt_word(input sblin_evt_t e);
      logic [31:0] w;
      w = 32'h00000000;
      w[`SBLIN_BIT_HTE]     = e.hdr_timeout;
      w[`SBLIN_BIT_STE]     = e.sync_tol;
      w[`SBLIN_BIT_SNRE]    = e.resp_silent;
      w[`SBLIN_BIT_CE]      = e.checksum;
      w[`SBLIN_BIT_IPE]     = e.id_parity;
      w[`SBLIN_BIT_ISFE]    = e.incons_sync;
      w[`SBLIN_BIT_BE]      = e.bit_err;
      w[`SBLIN_BIT_TIMEOUT] = e.rx_timeout;
      w[`SBLIN_BIT_PARITY_ERR_FLAG]    = e.parity;
      w[`SBLIN_BIT_FRAME]   = e.framing;
      w[`SBLIN_BIT_OVERRUN_FLAG]    = e.overrun;
      return w;
   endfunction

   logic [31:0] sticky_reg;
   logic [31:0] sticky_next;
   logic [31:0] istat_reg;
   logic [31:0] istat_next;
   logic [31:0] imask_reg;
   logic [31:0] baud_reg;
   logic [3:0]  mode_reg;
   logic        over_reg;
   logic [31:0] rd_next;
   logic        irq_next;
   logic        line_level;

   // Address decode
   wire logic hit_ctrl_w  = addr_i == `SBLIN_OFF_CTRL;
   wire logic hit_mode_w  = addr_i == `SBLIN_OFF_MODE;
   wire logic hit_stat_w  = addr_i == `SBLIN_OFF_STAT;
   wire logic hit_baud_w  = addr_i == `SBLIN_OFF_BAUD;
   wire logic hit_istat_w = addr_i == `SBLIN_OFF_ISTAT;
   wire logic hit_imask_w = addr_i == `SBLIN_OFF_IMASK;

   wire logic wr_ctrl_w  = wr_stb_i && hit_ctrl_w;
   wire logic wr_mode_w  = wr_stb_i && hit_mode_w;
   wire logic wr_baud_w  = wr_stb_i && hit_baud_w;
   wire logic wr_istat_w = wr_stb_i && hit_istat_w;
   wire logic wr_imask_w = wr_stb_i && hit_imask_w;

   wire logic clr_status_w = wr_ctrl_w && wr_data_i[`SBLIN_CTRL_CLR_BIT];

   wire logic lin_mode_w = (mode_reg == `SBLIN_LIN_MODE_A)
                        || (mode_reg == `SBLIN_LIN_MODE_B);

   wire logic [31:0] set_w = evt_word(evt_i) & `SBLIN_STICKY_MASK;

   // Set wins over a clear in the same cycle, so no error is lost
   assign sticky_next = clr_status_w ? set_w : (sticky_reg | set_w);
   assign istat_next  = (istat_reg & ~(wr_istat_w ? wr_data_i : 32'h00000000)) | set_w;

   // Live levels placed at their status positions
   wire logic [31:0] level_word_w = {8'h00, line_level, 7'h00,
                                     lvl_i.xfer_done, lvl_i.ident, lvl_i.brk, 3'b000,
                                     lvl_i.tx_drained, 1'b0, 6'h00,
                                     lvl_i.tx_room, lvl_i.rx_avail};

   // Outside LIN modes the LIN-only fields are hidden
   wire logic [31:0] stat_raw_w  = sticky_reg | level_word_w;
   wire logic [31:0] stat_word_w = lin_mode_w ? stat_raw_w
                                              : (stat_raw_w & ~`SBLIN_LIN_ONLY_MASK);

   wire sblin_baud_cfg_t baud_cfg_w = '{
      fraction_part:         baud_reg[`SBLIN_FP_MSB:`SBLIN_FP_LSB],
      clock_divisor:         baud_reg[`SBLIN_CD_MSB:`SBLIN_CD_LSB],
      sampling_ratio_select: over_reg
   };

   // Control register is command-only and reads zero; status ignores writes
   assign rd_next = !rd_stb_i   ? 32'h00000000 :
                    hit_mode_w  ? {12'h000, over_reg, 15'h0000, mode_reg} :
                    hit_stat_w  ? stat_word_w :
                    hit_baud_w  ? baud_reg :
                    hit_istat_w ? istat_reg :
                    hit_imask_w ? imask_reg : 32'h00000000;

   assign irq_next = |(istat_next & imask_reg);

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sticky_reg <= `SBLIN_RST_WORD;
         istat_reg  <= `SBLIN_RST_WORD;
         rd_data_o  <= `SBLIN_RST_WORD;
         irq_o      <= 1'b0;
         lin_mode_o <= 1'b0;
      end else begin
         sticky_reg <= sticky_next;
         istat_reg  <= istat_next;
         rd_data_o  <= rd_next;
         irq_o      <= irq_next;
         lin_mode_o <= lin_mode_w;
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         imask_reg <= `SBLIN_RST_WORD;
         baud_reg  <= `SBLIN_RST_BAUD;
         mode_reg  <= `SBLIN_RST_MODE;
         over_reg  <= 1'b0;
      end else begin
         if (wr_imask_w) begin
            imask_reg <= wr_data_i & `SBLIN_STICKY_MASK;
         end
         if (wr_baud_w) begin
            baud_reg <= {13'h0000, wr_data_i[`SBLIN_FP_MSB:0]};
         end
         if (wr_mode_w) begin
            mode_reg <= wr_data_i[`SBLIN_MODE_MSB:`SBLIN_MODE_LSB];
            over_reg <= wr_data_i[`SBLIN_OVER_BIT];
         end
      end
   end

   // Line state needs the filtered pin; a raw sample could read as a glitch
   sblin_pin_sync #(
      .WIDTH (1)
   ) u_rx_sync (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .pin_i      (line_rx_i),
      .level_o    (line_level)
   );

   sblin_baud_gen #(
      .CD_W (CD_W)
   ) u_baud (
      .core_clk_i    (core_clk_i),
      .sys_rst_i     (sys_rst_i),
      .cfg_i         (baud_cfg_w),
      .sample_tick_o (sample_tick_o),
      .bit_tick_o    (bit_tick_o)
   );

endmodule

`default_nettype wire

// file: verification/sblin_node_model.sv
/* Model of the serial engine and remote node facing sblin_top.
   Assumes the bench calls its tasks; outputs change after rising edges. */
`timescale 1ns/10ps
`default_nettype none
module sblin_node_model
   import sblin_pkg::*;
(
   input  wire logic       core_clk_i,
   output var  sblin_evt_t evt_o,
   output var  sblin_lvl_t lvl_o,
   output var  logic       line_o
);
   initial begin
      evt_o = '0;
      lvl_o = '0;
      line_o = 1'b1;
   end
   // Error reports are single-cycle pulses
   task automatic pulse(input sblin_evt_t e);
      @(posedge core_clk_i);
      evt_o <= e;
      @(posedge core_clk_i);
      evt_o <= '0;
   endtask
   task automatic levels(input sblin_lvl_t l, input logic line);
      @(posedge core_clk_i);
      lvl_o <= l;
      line_o <= line;
   endtask
endmodule
`default_nettype wire

// file: verification/sblin_top_monitor.sv
/* Checker on the ports of sblin_top.
   Assumes it is bound to sblin_top and sees one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module sblin_top_monitor
   import sblin_pkg::*;
(
   input wire logic        core_clk_i,
   input wire logic        sys_rst_i,
   input wire logic [7:0]  addr_i,
   input wire logic [31:0] wr_data_i,
   input wire logic        wr_stb_i,
   input wire logic        rd_stb_i,
   input wire logic [31:0] rd_data_o,
   input wire sblin_evt_t  evt_i,
   input wire sblin_lvl_t  lvl_i,
   input wire logic        sample_tick_o,
   input wire logic        bit_tick_o,
   input wire logic        lin_mode_o,
   input wire logic        irq_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic [31:0] mask_reg;
   logic [18:0] baud_reg;
   logic [15:0] gap_reg;
   logic        seen_reg;
   logic        lin_reg;
   logic        cfg_d_reg;
   wire  [31:0] evt_word = {evt_i[10:4], 16'h0, evt_i[3:0], 5'h0};
   wire  [2:0]  lvl_bits = {lvl_i.tx_drained, lvl_i.tx_room, lvl_i.rx_avail};
   wire         rd_stat  = rd_stb_i && addr_i == 8'h14;
   wire         irq_wr   = wr_stb_i && (addr_i == 8'h28 || addr_i == 8'h2c);
   wire         cfg_wr   = wr_stb_i && (addr_i == 8'h20 || addr_i == 8'h04);
   wire         lin_val  = wr_data_i[3:0] == 4'ha || wr_data_i[3:0] == 4'hb;
   // Shadows keep the programmed figures so checks use exact counts
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mask_reg <= 32'h0;
         baud_reg <= 19'h0;
         gap_reg <= 16'h0;
         seen_reg <= 1'b0;
         lin_reg <= 1'b0;
         cfg_d_reg <= 1'b0;
      end else begin
         lin_reg <= (wr_stb_i && addr_i == 8'h04) ? lin_val : lin_reg;
         cfg_d_reg <= cfg_wr;
         mask_reg <= (wr_stb_i && addr_i == 8'h2c) ? wr_data_i : mask_reg;
         baud_reg <= (wr_stb_i && addr_i == 8'h20) ? wr_data_i[18:0] : baud_reg;
         gap_reg <= sample_tick_o ? 16'h0 : gap_reg + 16'h1;
         // The divider restarts the cycle after a config write, so skip ticks around it
         seen_reg <= (cfg_wr || cfg_d_reg) ? 1'b0 : (sample_tick_o | seen_reg);
      end
   end
   property p_rd_idle; !rd_stb_i |=> rd_data_o == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data off cycle");
   property p_unused; rd_stat |=> (rd_data_o & 32'h017f1c1c) == 32'h0; endproperty
   a_unused: assert property (p_unused) else $error("unused status bit set");
   // The mode flag is registered from the mode field, so it lags the write by a cycle
   property p_mode; wr_stb_i && addr_i == 8'h04 |=> ##1 lin_mode_o == $past(lin_reg); endproperty
   a_mode: assert property (p_mode) else $error("mode flag wrong");
   property p_hide;
      rd_stat && !lin_reg |=> rd_data_o[31:23] == 9'h0 && rd_data_o[15:13] == 3'h0;
   endproperty
   a_hide: assert property (p_hide) else $error("lin field shown outside mode");
   property p_levels; rd_stat |=> {rd_data_o[9], rd_data_o[1:0]} == $past(lvl_bits); endproperty
   a_levels: assert property (p_levels) else $error("level flags wrong");
   property p_irq_set; (evt_word & mask_reg) != 32'h0 && !irq_wr |=> irq_o; endproperty
   a_irq_set: assert property (p_irq_set) else $error("irq missing");
   property p_irq_fall; $fell(irq_o) |-> $past(irq_wr); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
   property p_bit_tick; bit_tick_o |-> sample_tick_o; endproperty
   a_bit_tick: assert property (p_bit_tick) else $error("bit tick off sample");
   property p_gap;
      sample_tick_o && seen_reg && baud_reg[18:16] == 3'h0 |-> gap_reg == baud_reg[15:0] - 16'h1;
   endproperty
   a_gap: assert property (p_gap) else $error("sample spacing wrong");
   c_lin_read: cover property (rd_stat && lin_mode_o);
   c_irq_fall: cover property ($fell(irq_o));
   c_bit: cover property (bit_tick_o);
endmodule
`default_nettype wire

// file: verification/sblin_top_tb_top.sv
/* Bench for sblin_top: register tasks, event and level stimulus, baud timing.
   Assumes the node model drives the engine side and the monitor is bound. */
`timescale 1ns/10ps
`default_nettype none
module sblin_top_tb_top
   import sblin_pkg::*;
;
   logic        core_clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic [7:0]  addr_i = 8'h0;
   logic [31:0] wr_data_i = 32'h0;
   logic        wr_stb_i = 1'b0;
   logic        rd_stb_i = 1'b0;
   logic [31:0] rd_data_o, exp_w;
   sblin_evt_t  evt_i;
   sblin_lvl_t  lvl_i;
   logic        line_rx_i, sample_tick_o, bit_tick_o, lin_mode_o, irq_o;
   int          error_cnt = 0;
   int          cmp_count = 0;
   int          n;
   int          m;
   // Divisor settings give exact rates
   int          cds [3] = '{3, 2, 2};
   int          fps [3] = '{0, 4, 1};
   int          ovs [3] = '{0, 1, 0};
   localparam logic [31:0] LINE = 32'h00800000;
   always #12.5 core_clk_i = ~core_clk_i;
   sblin_top sblin_top_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
      .wr_data_i(wr_data_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i), .rd_data_o(rd_data_o),
      .evt_i(evt_i), .lvl_i(lvl_i), .line_rx_i(line_rx_i), .sample_tick_o(sample_tick_o),
      .bit_tick_o(bit_tick_o), .lin_mode_o(lin_mode_o), .irq_o(irq_o));
   sblin_node_model sblin_node_model_inst (.core_clk_i(core_clk_i), .evt_o(evt_i),
      .lvl_o(lvl_i), .line_o(line_rx_i));
   task automatic results;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      wr_stb_i <= 1'b1;
      addr_i <= a;
      wr_data_i <= d;
      @(posedge core_clk_i);
      wr_stb_i <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge core_clk_i);
      rd_stb_i <= 1'b1;
      addr_i <= a;
      @(posedge core_clk_i);
      rd_stb_i <= 1'b0;
      #1 check(rd_data_o, exp);
   endtask
   // Ticks are looked at just after the edge that launches them, once they have settled
   task automatic wait_bit(output int cnt, output int smp);
      cnt = 0;
      smp = 0;
      do begin
         @(posedge core_clk_i);
         #1;
         cnt++;
         if (sample_tick_o === 1'b1)
            smp++;
      end while (bit_tick_o !== 1'b1 && cnt < 2000);
      if (cnt >= 2000) begin
         error_cnt++;
         results();
      end
   endtask
   initial begin
      repeat (6) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      rd(8'h14, 32'h0);
      rd(8'h20, 32'h0);
      rd(8'h3c, 32'h0);
      wr(8'h2c, 32'hfe0001e0);
      rd(8'h2c, 32'hfe0001e0);
      wr(8'h04, 32'ha);
      @(posedge core_clk_i);
      #1 check({31'h0, lin_mode_o}, 32'h1);
      $display("test reset done");
      for (int i = 0; i < 11; i++) begin
         exp_w = 32'h1 << (i < 4 ? i + 5 : i + 21);
         sblin_node_model_inst.pulse(sblin_evt_t'(11'h1 << i));
         rd(8'h14, exp_w | LINE);
         check({31'h0, irq_o}, 32'h1);
         wr(8'h28, exp_w);
         rd(8'h14, exp_w | LINE);
         wr(8'h00, 32'h100);
         rd(8'h14, LINE);
         check({31'h0, irq_o}, 32'h0);
      end
      wr(8'h2c, 32'h0);
      sblin_node_model_inst.pulse(sblin_evt_t'(11'h400));
      #1 check({31'h0, irq_o}, 32'h0);
      rd(8'h28, 32'h80000000);
      wr(8'h04, 32'h0);
      @(posedge core_clk_i);
      #1 check({31'h0, lin_mode_o}, 32'h0);
      rd(8'h14, 32'h0);
      wr(8'h04, 32'hb);
      rd(8'h14, 32'h80000000 | LINE);
      wr(8'h00, 32'h100);
      wr(8'h28, 32'h80000000);
      rd(8'h28, 32'h0);
      $display("test events done");
      // Line passes a synchroniser, so let it settle before reading
      sblin_node_model_inst.levels(sblin_lvl_t'(6'h3f), 1'b0);
      repeat (5) @(posedge core_clk_i);
      rd(8'h14, 32'h0000e203);
      wr(8'h14, 32'hffffffff);
      wr(8'h04, 32'h0);
      rd(8'h14, 32'h00000203);
      $display("test levels done");
      for (int k = 0; k < 3; k++) begin
         wr(8'h04, (32'(ovs[k]) << 19) | 32'ha);
         wr(8'h20, (32'(fps[k]) << 16) | 32'(cds[k]));
         wait_bit(n, m);
         wait_bit(n, m);
         check(32'(n), 32'((2 - ovs[k]) * (8 * cds[k] + fps[k])));
         check(32'(m), 32'(8 * (2 - ovs[k])));
      end
      $display("test baud done");
      results();
   end
endmodule
bind sblin_top sblin_top_monitor sblin_top_monitor_inst (.core_clk_i(core_clk_i),
   .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_stb_i(wr_stb_i),
   .rd_stb_i(rd_stb_i), .rd_data_o(rd_data_o), .evt_i(evt_i), .lvl_i(lvl_i),
   .sample_tick_o(sample_tick_o), .bit_tick_o(bit_tick_o), .lin_mode_o(lin_mode_o),
   .irq_o(irq_o));
`default_nettype wire
